// >>> src/tc0io_top.sv
/*
 timer channel 0 capture/compare pin control with wishbone slave.
 assumes the channel counter and channel-1 count event come from
 logic on clk; pins arrive asynchronously and are synchronised here.
*/
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - buffer a set pairs c with a
// - buffer b set pairs d with b
// - code 0x00 off, 0x01 low, bit2 initial level
// - code 0x10 drives high at match
// - code 0x11 toggles at match
// - code 1000 captures on rising edge
// - code 1001 captures on falling edge
// - code 101x captures on both edges
// - code 11xx captures on channel 1 count
// - channel 1 undivided clock blocks that capture
// - buffered c ignores its code
// - buffered d ignores its code
// - low control register: d high, c low
// - buffered c/d act purely as buffers
// - buffered c/d never clear the counter
module tc0io_top #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // wishbone slave
    input  wire logic              wbCycI,
    input  wire logic              wbStbI,
    input  wire logic              wbWeI,
    input  wire logic [17:0]       wbAdrI,
    input  wire logic [3:0]        wbSelI,
    input  wire logic [31:0]       wbDatI,
    output logic      [31:0]       wbDatO,
    output logic                   wbAckO,
    // timer core, same clock
    input  wire logic [CNT_W-1:0]  channelCounter,
    input  wire logic              ch1CountEvt,
    output logic                   counterClr,
    // pins a..d: input, level, enable
    input  wire logic [3:0]        pinIn,
    output var tc0io_pkg::tc0io_pinDrv_t pinDrv
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    tc0io_pkg::tc0io_busSt_t busSt_r;   // bus slave state
    logic [7:0]       ioHigh_r;          // codes a, b
    logic [7:0]       ioLow_r;           // codes c, d
    logic [7:0]       mode_r;            // buffer enables
    logic [7:0]       cfg_r;             // prescale and clear select
    logic [CNT_W-1:0] genReg_r [4];      // general regs a..d
    logic [3:0]       pinS1_r;           // sync stage 1
    logic [3:0]       pinS2_r;           // sync stage 2
    logic [3:0]       pinS3_r;           // previous synced level
    logic [15:0]      codePrev_r;        // codes last cycle
    logic [3:0]       ioCode [4];        // per register code
    logic [3:0]       inhib;             // register is a buffer
    logic [3:0]       match;             // compare match event
    logic [3:0]       capHit;            // capture event
    logic [1:0]       bufEn;             // buffer a, buffer b
    logic [2:0]       pscSel;
    logic [2:0]       clrSel;
    logic             busReq;
    logic             busWr;
    logic [15:0]      idx;
    logic [15:0]      codeAll;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // capture condition for one code; shared by all four registers
    function automatic logic capFor(input logic [3:0] c, input logic rise,
                                    input logic fall, input logic ch1Ok);
        logic r;
        r = 1'b0;
        if (c[tc0io_pkg::CODE_CAP]) begin
            if (c[tc0io_pkg::CODE_CH1])
                r = ch1Ok;
            else if (c[tc0io_pkg::CODE_BOTH])
                r = rise | fall;
            else if (c[tc0io_pkg::CODE_FALL])
                r = fall;
            else
                r = rise;
        end
        return r;
    endfunction

    // byte-lane merge used by the four general registers
    function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0] s);
        logic [15:0] r;
        r = old;
        if (s[0])
            r[7:0] = d[7:0];
        if (s[1])
            r[15:8] = d[15:8];
        return r;
    endfunction

    // ------------------------------------------------------------
    // event decode
    // ------------------------------------------------------------
    assign idx     = wbAdrI[17:2];
    assign busReq  = wbCycI & wbStbI & (busSt_r == tc0io_pkg::BUS_IDLE);
    assign busWr   = busReq & wbWeI;
    assign bufEn   = {mode_r[tc0io_pkg::MODE_BFB_POS],
                      mode_r[tc0io_pkg::MODE_BFA_POS]};
    assign pscSel  = cfg_r[tc0io_pkg::CFG_PSC_LSB +: 3];
    assign clrSel  = cfg_r[tc0io_pkg::CFG_CLR_LSB +: 3];
    assign ioCode[0] = ioHigh_r[3:0];
    assign ioCode[1] = ioHigh_r[7:4];
    assign ioCode[2] = ioLow_r[3:0];
    assign ioCode[3] = ioLow_r[7:4];
    assign codeAll = {ioLow_r, ioHigh_r};
    // c and d become plain buffers; their codes are dead while paired
    assign inhib   = {bufEn[1], bufEn[0], 2'b00};

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            match[i]  = ~ioCode[i][tc0io_pkg::CODE_CAP] & ~inhib[i]
                      & (channelCounter == genReg_r[i]);
            // an undivided channel 1 clock cannot be seen as events
            capHit[i] = ~inhib[i] & capFor(ioCode[i],
                        pinS2_r[i] & ~pinS3_r[i],
                        ~pinS2_r[i] & pinS3_r[i],
                        ch1CountEvt & (pscSel != tc0io_pkg::PSC_UNDIV));
        end
    end

    // ------------------------------------------------------------
    // pin synchronisers; stage 1 feeds stage 2 only
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinS1_r <= 4'h0;
            pinS2_r <= 4'h0;
            pinS3_r <= 4'h0;
        end else begin
            pinS1_r <= pinIn;
            pinS2_r <= pinS1_r;
            pinS3_r <= pinS2_r;
        end
    end

    // ------------------------------------------------------------
    // wishbone slave: one wait state, ack for one cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busSt_r <= tc0io_pkg::BUS_IDLE;
            wbAckO  <= 1'b0;
            wbDatO  <= 32'h0000_0000;
        end else begin
            case (busSt_r)
                tc0io_pkg::BUS_IDLE: begin
                    if (busReq) begin
                        busSt_r <= tc0io_pkg::BUS_ACK;
                        wbAckO  <= 1'b1;
                        wbDatO  <= 32'h0000_0000;       // unmapped reads 0
                        case (idx)
                            tc0io_pkg::IDX_CFG:  wbDatO[7:0] <= cfg_r;
                            tc0io_pkg::IDX_MODE: wbDatO[7:0] <= mode_r;
                            tc0io_pkg::IDX_IOH:  wbDatO[7:0] <= ioHigh_r;
                            tc0io_pkg::IDX_IOL:  wbDatO[7:0] <= ioLow_r;
                            tc0io_pkg::IDX_STAT: wbDatO[7:0] <= {pinS2_r, pinDrv.lvl};
                            default: begin
                                for (int i = 0; i < 4; i++) begin
                                    if (idx == tc0io_pkg::IDX_GR0 + 16'(i))
                                        wbDatO[CNT_W-1:0] <= genReg_r[i];
                                end
                            end
                        endcase
                    end
                end
                tc0io_pkg::BUS_ACK: begin
                    busSt_r <= tc0io_pkg::BUS_IDLE;     // drop ack next cycle
                    wbAckO  <= 1'b0;
                end
                default: begin
                    busSt_r <= tc0io_pkg::BUS_IDLE;
                    wbAckO  <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // control registers, lane 0 only
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ioHigh_r <= tc0io_pkg::RST_IO;
            ioLow_r  <= tc0io_pkg::RST_IO;
            mode_r   <= tc0io_pkg::RST_MODE;
            cfg_r    <= tc0io_pkg::RST_CFG;
        end else if (busWr && wbSelI[0]) begin
            if (idx == tc0io_pkg::IDX_IOH)
                ioHigh_r <= wbDatI[7:0];
            if (idx == tc0io_pkg::IDX_IOL)
                ioLow_r <= wbDatI[7:0];
            if (idx == tc0io_pkg::IDX_MODE)
                mode_r <= wbDatI[7:0] & 8'h30;
            if (idx == tc0io_pkg::IDX_CFG)
                cfg_r <= wbDatI[7:0] & 8'h3F;
        end
    end

    // ------------------------------------------------------------
    // general registers: capture and buffer moves beat bus writes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 4; i++)
                genReg_r[i] <= tc0io_pkg::RST_GR;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (busWr && idx == tc0io_pkg::IDX_GR0 + 16'(i))
                    genReg_r[i] <= CNT_W'(laneMerge(16'(genReg_r[i]),
                                                    wbDatI, wbSelI));
            end
            for (int i = 0; i < 2; i++) begin
                // capture pushes the old value into the buffer
                if (bufEn[i] && capHit[i])
                    genReg_r[i+2] <= genReg_r[i];
                if (capHit[i])
                    genReg_r[i] <= channelCounter;
                else if (bufEn[i] && match[i])
                    genReg_r[i] <= genReg_r[i+2];
            end
            for (int i = 2; i < 4; i++) begin
                if (capHit[i])
                    genReg_r[i] <= channelCounter;
            end
        end
    end

    // ------------------------------------------------------------
    // pin drive: initial level the cycle after a code change
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinDrv     <= '0;
            codePrev_r <= 16'h0000;
        end else begin
            codePrev_r <= codeAll;
            for (int i = 0; i < 4; i++) begin
                // compare mode with a non-zero action drives the pin unless the register is a buffer
                pinDrv.oe[i] <= ~ioCode[i][tc0io_pkg::CODE_CAP] & ~inhib[i]
                              & (ioCode[i][1:0] != tc0io_pkg::ACT_OFF);
                if (codeAll[4*i +: 4] != codePrev_r[4*i +: 4])
                    pinDrv.lvl[i] <= ioCode[i][tc0io_pkg::CODE_INIT];
                else if (match[i]) begin
                    case (ioCode[i][1:0])
                        tc0io_pkg::ACT_LOW:  pinDrv.lvl[i] <= 1'b0;
                        tc0io_pkg::ACT_HIGH: pinDrv.lvl[i] <= 1'b1;
                        tc0io_pkg::ACT_TGL:  pinDrv.lvl[i] <= ~pinDrv.lvl[i];
                        default:             pinDrv.lvl[i] <= pinDrv.lvl[i];
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // counter clear pulse; buffers never match or capture
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            counterClr <= 1'b0;
        else begin
            case (clrSel)
                tc0io_pkg::CLR_A: counterClr <= match[0] | capHit[0];
                tc0io_pkg::CLR_B: counterClr <= match[1] | capHit[1];
                tc0io_pkg::CLR_C: counterClr <= match[2] | capHit[2];
                tc0io_pkg::CLR_D: counterClr <= match[3] | capHit[3];
                default:          counterClr <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // register c carries the compare and capture traffic of the bench
    sequence s_stableCodeC;
        codeAll[11:8] == codePrev_r[11:8];
    endsequence
    sequence s_matchC;
        match[2] ##0 s_stableCodeC;
    endsequence

    property p_bufCapA;
        bufEn[0] && capHit[0] |=> genReg_r[2] == $past(genReg_r[0]);
    endproperty
    a_bufCapA: assert property (p_bufCapA) else $error("c not loaded");
    property p_bufCapB;
        bufEn[1] && capHit[1] |=> genReg_r[3] == $past(genReg_r[1]);
    endproperty
    a_bufCapB: assert property (p_bufCapB) else $error("d not loaded");
    property p_lowAtMatch;
        s_matchC ##0 ioCode[2][1:0] == tc0io_pkg::ACT_LOW
            |=> !pinDrv.lvl[2] ##0 pinDrv.oe[2];
    endproperty
    a_lowAtMatch: assert property (p_lowAtMatch) else $error("no low");
    property p_highAtMatch;
        s_matchC ##0 ioCode[2][1:0] == tc0io_pkg::ACT_HIGH |=> pinDrv.lvl[2];
    endproperty
    a_highAtMatch: assert property (p_highAtMatch) else $error("no high");
    property p_toggle;
        s_matchC ##0 ioCode[2][1:0] == tc0io_pkg::ACT_TGL
            |=> pinDrv.lvl[2] != $past(pinDrv.lvl[2]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle");
    // capture beats a bus write, so no write guard is needed here
    property p_rise;
        ioCode[2] == 4'h8 && !bufEn[0] && pinS2_r[2] && !pinS3_r[2]
            |=> genReg_r[2] == $past(channelCounter);
    endproperty
    a_rise: assert property (p_rise) else $error("rise missed");
    property p_fall;
        ioCode[2] == 4'h9 && !bufEn[0] && $fell(pinS2_r[2]) |-> capHit[2];
    endproperty
    a_fall: assert property (p_fall) else $error("fall missed");
    property p_both;
        ioCode[2][3:1] == 3'h5 && !bufEn[0] && $changed(pinS2_r[2]) |-> capHit[2];
    endproperty
    a_both: assert property (p_both) else $error("edge missed");
    property p_ch1;
        ioCode[2][3:2] == 2'h3 && !bufEn[0]
            |-> capHit[2] == (ch1CountEvt && pscSel != tc0io_pkg::PSC_UNDIV);
    endproperty
    a_ch1: assert property (p_ch1) else $error("ch1 capture");
    property p_bufC;
        bufEn[0] [*2] |-> !match[2] && !capHit[2] ##0 !pinDrv.oe[2];
    endproperty
    a_bufC: assert property (p_bufC) else $error("c not inert");
    property p_bufD;
        bufEn[1] [*2] |-> !match[3] && !capHit[3] ##0 !pinDrv.oe[3];
    endproperty
    a_bufD: assert property (p_bufD) else $error("d not inert");
    property p_iolWrite;
        busWr && wbSelI[0] && idx == tc0io_pkg::IDX_IOL
            |=> ioLow_r == $past(wbDatI[7:0]);
    endproperty
    a_iolWrite: assert property (p_iolWrite) else $error("iol write");
    property p_noClr;
        bufEn[0] && clrSel == tc0io_pkg::CLR_C |=> !counterClr;
    endproperty
    a_noClr: assert property (p_noClr) else $error("buffer cleared");
    property p_bufMatch;
        bufEn[0] && match[0] && !capHit[0] |=> genReg_r[0] == $past(genReg_r[2]);
    endproperty
    a_bufMatch: assert property (p_bufMatch) else $error("no transfer");
    property p_ackOne;
        busReq |=> wbAckO ##1 !wbAckO;
    endproperty
    a_ackOne: assert property (p_ackOne) else $error("ack shape");
endmodule
`default_nettype wire

// >>> src/tc0io_pkg.sv
/*
 timer channel 0 i/o control: register indexes, field positions,
 reset values, pin carrier and bus states.
 assumes a 32-bit classic wishbone bus, byte address = 4 * index.
*/
package tc0io_pkg;
    // ------------------------------------------------------------
    // register indexes
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_CFG  = 16'hFFD0; // psc + clear sel
    localparam logic [15:0] IDX_MODE = 16'hFFD1; // buffer enables
    localparam logic [15:0] IDX_IOH  = 16'hFFD2; // codes a (3:0) b (7:4)
    localparam logic [15:0] IDX_IOL  = 16'hFFD3; // codes c (3:0) d (7:4)
    localparam logic [15:0] IDX_STAT = 16'hFFD4; // pin state, read only
    localparam logic [15:0] IDX_GR0  = 16'hFFD8; // general regs a..d
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_BFA_POS = 4;
    localparam int MODE_BFB_POS = 5;
    localparam int CFG_PSC_LSB  = 0;
    localparam int CFG_CLR_LSB  = 3;
    localparam int CODE_CAP     = 3; // 1: input capture
    localparam int CODE_CH1     = 2; // capture source channel 1
    localparam int CODE_INIT    = 2; // initial pin level
    localparam int CODE_BOTH    = 1;
    localparam int CODE_FALL    = 0;
    // ------------------------------------------------------------
    // reset values and encodings
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_IO   = 8'h00;
    localparam logic [7:0]  RST_MODE = 8'h00;
    localparam logic [7:0]  RST_CFG  = 8'h00;
    localparam logic [15:0] RST_GR   = 16'h0000;
    localparam logic [2:0]  PSC_UNDIV = 3'h0;
    localparam logic [1:0]  ACT_OFF  = 2'h0;
    localparam logic [1:0]  ACT_LOW  = 2'h1;
    localparam logic [1:0]  ACT_HIGH = 2'h2;
    localparam logic [1:0]  ACT_TGL  = 2'h3;
    localparam logic [2:0]  CLR_A    = 3'h1;
    localparam logic [2:0]  CLR_B    = 3'h2;
    localparam logic [2:0]  CLR_C    = 3'h5;
    localparam logic [2:0]  CLR_D    = 3'h6;
    // pin drive carrier
    typedef struct packed {
        logic [3:0] lvl;
        logic [3:0] oe;
    } tc0io_pinDrv_t;
    // bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } tc0io_busSt_t;
endpackage

// >>> sim/tc0io_pin_model.sv
/*
 external circuitry on timer channel 0 pins a..d.
 assumes the bench commands the outside level; the design's enable wins.
*/
`timescale 1ns/1ps
`default_nettype none
module tc0io_pin_model (
    // design drive
    input  wire tc0io_pkg::tc0io_pinDrv_t pinDrv,
    // outside level commanded by the bench
    input  wire logic [3:0]               extLvl,
    // resolved pin levels
    output logic      [3:0]               pinIn
);
    // ---------------------------------------------
    // wire resolution
    // ---------------------------------------------
    // a driven pin shows the design level, else the outside source
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pinIn[i] = pinDrv.oe[i] ? pinDrv.lvl[i] : extLvl[i];
        end
    end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
/*
 self-checking bench for timer channel 0 pin control.
 assumes 1-cycle wishbone ack and pins synchronised within 8 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ---------------------------------------------
    // signals
    // ---------------------------------------------
    logic                     clk, nrst, wbCycI, wbStbI, wbWeI, wbAckO;
    logic                     ch1CountEvt, counterClr;
    logic [17:0]              wbAdrI;
    logic [3:0]               wbSelI, pinIn, extLvl;
    logic [31:0]              wbDatI, wbDatO, rdat;
    logic [15:0]              cnt;
    tc0io_pkg::tc0io_pinDrv_t pinDrv;
    int                       failures, samplesChecked, clrCount, c0;

    tc0io_top u_dut (.clk(clk), .nrst(nrst), .wbCycI(wbCycI), .wbStbI(wbStbI),
        .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI),
        .wbDatO(wbDatO), .wbAckO(wbAckO), .channelCounter(cnt),
        .ch1CountEvt(ch1CountEvt), .counterClr(counterClr), .pinIn(pinIn),
        .pinDrv(pinDrv));
    tc0io_pin_model u_pins (.pinDrv(pinDrv), .extLvl(extLvl), .pinIn(pinIn));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // counts clear pulses so a window can be judged
    always @(posedge clk) begin
        if (counterClr === 1'b1) clrCount <= clrCount + 1;
    end
    // ---------------------------------------------
    // shared tasks
    // ---------------------------------------------
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [15:0] idx, input logic [15:0] d);
        int n;
        n = 0;
        wbCycI <= 1'b1;
        wbStbI <= 1'b1;
        wbWeI  <= we;
        wbAdrI <= {idx, 2'b00};
        wbDatI <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (wbAckO !== 1'b1 && n < 20);
        rdat = wbDatO;
        wbCycI <= 1'b0;
        wbStbI <= 1'b0;
        if (n >= 20) begin
            failures++;
            conclude();
        end
        @(posedge clk);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // counter equals v for exactly one sampled edge
    task automatic hit(input logic [15:0] v);
        cnt <= v;
        @(posedge clk);
        cnt <= 16'h0100;
        tick(3);
    endtask
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic testRegs();
        wb(0, tc0io_pkg::IDX_IOL, 16'h0000);
        check(rdat[15:0], 16'h0000);
        wb(1, tc0io_pkg::IDX_IOL, 16'h00A5);
        wb(0, tc0io_pkg::IDX_IOL, 16'h0000);
        check(rdat[15:0], 16'h00A5);
        wb(0, 16'hFFE0, 16'h0000);
        check(rdat[15:0], 16'h0000);
        $display("register test done");
    endtask
    // table: code, then level after code change, first and second match
    task automatic testCompare();
        logic [3:0] codes [5] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h7};
        logic [2:0] exps  [5] = '{3'b000, 3'b011, 3'b010, 3'b100, 3'b101};
        wb(1, tc0io_pkg::IDX_GR0 + 16'h0002, 16'h0040);
        for (int i = 0; i < 5; i++) begin
            wb(1, tc0io_pkg::IDX_IOL, {12'h000, codes[i]});
            tick(2);
            check(16'(pinDrv.oe[2]), 16'h0001);
            check(16'(pinDrv.lvl[2]), 16'(exps[i][2]));
            hit(16'h0040);
            check(16'(pinDrv.lvl[2]), 16'(exps[i][1]));
            hit(16'h0040);
            check(16'(pinDrv.lvl[2]), 16'(exps[i][0]));
        end
        wb(1, tc0io_pkg::IDX_IOL, 16'h0000);
        tick(2);
        check(16'(pinDrv.oe[2]), 16'h0000);
        $display("compare test done");
    endtask
    // rising, falling and both-edge capture on pin c
    task automatic testCapture();
        logic [15:0] e1;
        for (int c = 8; c < 11; c++) begin
            wb(1, tc0io_pkg::IDX_IOL, 16'(c));
            tick(6);
            wb(1, tc0io_pkg::IDX_GR0 + 16'h0002, 16'h0000);
            e1 = (c != 9) ? 16'h1111 : 16'h0000;
            cnt <= 16'h1111;
            extLvl[2] <= 1'b1;
            tick(8);
            wb(0, tc0io_pkg::IDX_GR0 + 16'h0002, 16'h0000);
            check(rdat[15:0], e1);
            cnt <= 16'h2222;
            extLvl[2] <= 1'b0;
            tick(8);
            wb(0, tc0io_pkg::IDX_GR0 + 16'h0002, 16'h0000);
            check(rdat[15:0], (c != 8) ? 16'h2222 : e1);
        end
        $display("capture test done");
    endtask
    // channel-1 sourced capture, blocked then allowed by the prescaler
    task automatic testCh1();
        wb(1, tc0io_pkg::IDX_IOL, 16'h000C);
        wb(1, tc0io_pkg::IDX_GR0 + 16'h0002, 16'h0000);
        cnt <= 16'h5555;
        for (int p = 0; p < 2; p++) begin
            wb(1, tc0io_pkg::IDX_CFG, 16'(p));
            ch1CountEvt <= 1'b1;
            @(posedge clk);
            ch1CountEvt <= 1'b0;
            tick(3);
            wb(0, tc0io_pkg::IDX_GR0 + 16'h0002, 16'h0000);
            check(rdat[15:0], (p == 0) ? 16'h0000 : 16'h5555);
        end
        $display("channel 1 test done");
    endtask
    // c and d as buffers: no match, no clear, transfer into a and b
    task automatic testBuffer();
        wb(1, tc0io_pkg::IDX_GR0, 16'h0200);
        wb(1, tc0io_pkg::IDX_GR0 + 16'h0001, 16'h0400);
        wb(1, tc0io_pkg::IDX_GR0 + 16'h0002, 16'h0300);
        wb(1, tc0io_pkg::IDX_GR0 + 16'h0003, 16'h0500);
        wb(1, tc0io_pkg::IDX_IOH, 16'h0022);
        wb(1, tc0io_pkg::IDX_IOL, 16'h0033);
        wb(1, tc0io_pkg::IDX_CFG, 16'h0029);
        wb(1, tc0io_pkg::IDX_MODE, 16'h0030);
        tick(3);
        c0 = clrCount;
        hit(16'h0300);
        hit(16'h0500);
        check(16'(pinDrv.oe[2]), 16'h0000);
        check(16'(pinDrv.oe[3]), 16'h0000);
        check(16'(clrCount - c0), 16'h0000);
        hit(16'h0200);
        hit(16'h0400);
        check(16'(pinDrv.lvl[0]), 16'h0001);
        wb(0, tc0io_pkg::IDX_GR0, 16'h0000);
        check(rdat[15:0], 16'h0300);
        wb(0, tc0io_pkg::IDX_GR0 + 16'h0001, 16'h0000);
        check(rdat[15:0], 16'h0500);
        // positive control: register a still clears the counter
        wb(1, tc0io_pkg::IDX_CFG, 16'h0009);
        c0 = clrCount;
        hit(16'h0300);
        check(16'(clrCount - c0), 16'h0001);
        $display("buffer test done");
    endtask
    // mid-run reset brings the control registers back to zero
    task automatic testReset();
        nrst <= 1'b0;
        tick(2);
        nrst <= 1'b1;
        @(posedge clk);
        wb(0, tc0io_pkg::IDX_IOL, 16'h0000);
        check(rdat[15:0], 16'h0000);
        wb(0, tc0io_pkg::IDX_MODE, 16'h0000);
        check(rdat[15:0], 16'h0000);
        check(16'(pinDrv.oe), 16'h0000);
        $display("reset test done");
    endtask
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        nrst = 1'b0;
        wbCycI = 1'b0;
        wbStbI = 1'b0;
        wbWeI = 1'b0;
        wbAdrI = 18'h0_0000;
        wbSelI = 4'hF;
        wbDatI = 32'h0000_0000;
        cnt = 16'h0100;
        ch1CountEvt = 1'b0;
        extLvl = 4'h0;
        failures = 0;
        samplesChecked = 0;
        clrCount = 0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        testRegs();
        testCompare();
        testCapture();
        testCh1();
        testBuffer();
        testReset();
        conclude();
    end
endmodule
`default_nettype wire
